/* fdic_core.sv */
// Purpose: Drive-side control of select, side, stepping, write, erase, motor
// Assumes: Host lines synchronous to core_clk_i, all active low
// Notes: Unit number jumper is sampled once, on the first edge after reset
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps

// Functional notes
// R1 - Act on inputs and open output gates only while own select is low; side select still sets the head select, motor-on the spindle, when unselected.
// R2 - Jumper ties the drive to one of four select lines.
// R3 - Activity indicator lights while the drive is selected.
// R4 - Side select low picks side 1 head, high picks side 0.
// R5 - Host waits a settling time after changing side before transfers.
// R6 - Host holds side select from write end until erase ends.
// R7 - Step pulse with direction low moves one track inward.
// R8 - Step pulse with direction high moves one track outward.
// R9 - Host waits seek plus settle after the final step.
// R10 - Write gate low arms writing; high means read mode.
// R11 - Write and erase only with gate low, selected, not protected.
// R12 - Each falling edge of write data reverses head current.
// R13 - Write data drives a toggle latch feeding the write amplifier.
// R14 - Erase turns on a programmed delay after write gate falls.
// R15 - Erase turns off a programmed delay after write gate rises.
// R16 - Erase delays come from programmable logic, not fixed timing.
// R17 - Spindle runs while motor-on is low, regardless of select.
// R18 - Host allows spin-up time before relying on rotation.
// R19 - Head load engages only with request low, rotating, ready low.
// R20 - Head never loads without media present.
// R21 - Host waits magnet settle time after head load.
// R22 - Ready goes low on index while rotating, high otherwise.
// R23 - Track zero indication low only over the outermost track.
// R24 - Each step rotates four phase outputs, order reversed outward.
module fdic_core
  import fdic_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [1:0] unit_jumper_i,
  input wire fdic_host_in_t host_i,
  input wire fdic_sense_t sense_i,
  output fdic_host_out_t host_o,
  output fdic_mech_out_t mech_o
);

  typedef struct packed {
    logic strap_done;
    logic [1:0] drive_id;
    logic step_n_d;
    logic wd_n_d;
    logic index_n_d;
    logic [FDIC_TRK_W-1:0] track;
    fdic_phase_t phase_idx;
    logic wr_latch;
    logic ready_n;
    logic spindle;
    logic [FDIC_DLY_W-1:0] erase_on_dly;
    logic [FDIC_DLY_W-1:0] erase_off_dly;
    logic [31:0] prdata;
    logic slverr;
  } fdic_core_st_t;

  fdic_core_st_t st;
  fdic_core_st_t next_st;
  logic selected;
  logic rotating;
  logic step_acc;
  logic wd_fall;
  logic index_fall;
  logic write_ok;
  logic head_load;
  logic erase;
  logic [31:0] status_word;
  logic [31:0] track_word;

  ////////////////////////////////////////////////////////////////////////////////
  // Qualifiers

  // Not selected until the jumper has been sampled
  assign selected = st.strap_done & ~host_i.drive_sel_n[st.drive_id]; // see R1 see R2
  assign rotating = st.spindle & sense_i.media_present;
  assign step_acc = selected & st.step_n_d & ~host_i.step_n;
  assign wd_fall = st.wd_n_d & ~host_i.write_data_n;
  assign index_fall = st.index_n_d & ~sense_i.index_n;
  assign write_ok = selected & ~host_i.write_gate_n & ~sense_i.notch_covered; // see R10 see R11
  // Media presence is part of rotating, so an empty drive never loads
  // Select gates the request too: ready is only driven to the host when selected
  assign head_load = selected & ~host_i.head_load_n & rotating & ~st.ready_n; // see R19 see R20

  fdic_erase_delay u_erase (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .write_on_i(write_ok),
    .on_dly_i(st.erase_on_dly),
    .off_dly_i(st.erase_off_dly),
    .erase_o(erase)
  ); // see R14 see R15 see R16

  assign status_word = {22'h000000, st.drive_id, ~sense_i.track_zero_n ? 1'b0 : 1'b1,
                        head_load, st.spindle, st.ready_n, erase, write_ok,
                        ~host_i.side_sel_n, selected};
  assign track_word = {22'h000000, st.phase_idx, st.track};

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st = st;
    next_st.step_n_d = host_i.step_n;
    next_st.wd_n_d = host_i.write_data_n;
    next_st.index_n_d = sense_i.index_n;
    next_st.spindle = ~host_i.motor_on_n; // see R17
    if (!st.strap_done) begin
      next_st.strap_done = 1'b1;
      next_st.drive_id = unit_jumper_i; // see R2
    end
    if (step_acc) begin
      if (!host_i.dir_n) begin
        next_st.phase_idx = fdic_phase_t'(st.phase_idx + 2'b01); // see R24
        if (st.track != FDIC_TRACK_MAX) begin
          next_st.track = st.track + 8'h01; // see R7
        end
      end else begin
        next_st.phase_idx = fdic_phase_t'(st.phase_idx - 2'b01); // see R24
        if (st.track != 8'h00) begin
          next_st.track = st.track - 8'h01; // see R8
        end
      end
    end else if (!sense_i.track_zero_n) begin
      // Sensor resyncs the count whenever the carrier rests on track 0 and no step is accepted that cycle
      next_st.track = 8'h00;
    end
    if (write_ok && wd_fall) begin
      next_st.wr_latch = ~st.wr_latch; // see R12 see R13
    end
    if (!rotating) begin
      next_st.ready_n = 1'b1; // see R22
    end else if (index_fall) begin
      next_st.ready_n = 1'b0; // see R22
    end
    // Read data captured in setup so it is a flop output in access
    if (psel_i && !penable_i) begin
      next_st.slverr = 1'b0;
      case (paddr_i)
        FDIC_ERASE_ON_OFS: next_st.prdata = {16'h0000, st.erase_on_dly};
        FDIC_ERASE_OFF_OFS: next_st.prdata = {16'h0000, st.erase_off_dly};
        FDIC_STATUS_OFS: next_st.prdata = status_word;
        FDIC_TRACK_OFS: next_st.prdata = track_word;
        default: begin
          next_st.prdata = 32'h00000000;
          next_st.slverr = 1'b1;
        end
      endcase
    end
    if (psel_i && penable_i && pwrite_i) begin
      case (paddr_i)
        FDIC_ERASE_ON_OFS: next_st.erase_on_dly = pwdata_i[FDIC_DLY_W-1:0]; // see R16
        FDIC_ERASE_OFF_OFS: next_st.erase_off_dly = pwdata_i[FDIC_DLY_W-1:0]; // see R16
        default: next_st.erase_on_dly = st.erase_on_dly;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '{strap_done: 1'b0, drive_id: 2'b00, step_n_d: 1'b1, wd_n_d: 1'b1,
              index_n_d: 1'b1, track: 8'h00, phase_idx: FDIC_PH_A, wr_latch: 1'b0,
              ready_n: 1'b1, spindle: 1'b0, erase_on_dly: FDIC_ERASE_ON_RST,
              erase_off_dly: FDIC_ERASE_OFF_RST, prdata: 32'h00000000, slverr: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Zero wait states; status is only ever a snapshot
  assign pready_o = 1'b1;
  assign prdata_o = st.prdata;
  assign pslverr_o = psel_i & penable_i & st.slverr;

  // Unselected drive releases every output line high
  assign host_o.ready_n = ~selected | st.ready_n; // see R1
  assign host_o.track0_n = ~selected | sense_i.track_zero_n; // see R1 see R23
  assign host_o.write_protect_n = ~selected | ~sense_i.notch_covered; // see R1
  assign host_o.index_n = ~selected | sense_i.index_n; // see R1

  assign mech_o.phase = 4'h1 << st.phase_idx; // see R24
  // Head select held even when unselected so an erase tail keeps its side
  assign mech_o.side1_head = ~host_i.side_sel_n; // see R4 see R6
  assign mech_o.write_enable = write_ok;
  assign mech_o.write_current = st.wr_latch;
  assign mech_o.erase = erase;
  assign mech_o.spindle = st.spindle;
  assign mech_o.head_load = head_load;
  assign mech_o.activity_led = selected; // see R3

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  led_select_a: assert property ( // see R3
    mech_o.activity_led |-> st.strap_done && !host_i.drive_sel_n[st.drive_id])
    else $error("indicator lit while not selected");

  unsel_gate_a: assert property ( // see R1
    host_i.drive_sel_n == 4'hF |-> host_o == 4'hF && !mech_o.write_enable)
    else $error("outputs active with no select low");

  step_in_a: assert property ( // see R7
    step_acc && !host_i.dir_n && st.track != FDIC_TRACK_MAX
    |=> st.track == $past(st.track) + 8'h01)
    else $error("inward step did not add one track");

  step_out_a: assert property ( // see R8
    step_acc && host_i.dir_n && st.track != 8'h00
    |=> st.track == $past(st.track) - 8'h01)
    else $error("outward step did not drop one track");

  phase_rot_a: assert property ( // see R24
    step_acc |=> mech_o.phase != $past(mech_o.phase) && $onehot(mech_o.phase))
    else $error("phase did not advance on step");

  no_step_a: assert property ( // see R24
    !step_acc |=> $stable(st.phase_idx))
    else $error("phase moved without a step");

  write_gate_a: assert property ( // see R11
    mech_o.write_enable |-> !host_i.write_gate_n && !sense_i.notch_covered
    && host_o.write_protect_n)
    else $error("write enabled while inhibited");

  wdata_flip_a: assert property ( // see R12
    write_ok && wd_fall |=> mech_o.write_current != $past(mech_o.write_current))
    else $error("head current not reversed");

  wdata_hold_a: assert property ( // see R13
    !(write_ok && wd_fall) |=> $stable(mech_o.write_current))
    else $error("head current changed without data edge");

  erase_on_a: assert property ( // see R14
    $rose(mech_o.erase) |-> write_ok && $past(write_ok))
    else $error("erase rose without write gate");

  erase_off_a: assert property ( // see R15
    $fell(mech_o.erase) |-> !write_ok && $past(!write_ok))
    else $error("erase fell while writing");

  spindle_a: assert property ( // see R17
    host_i.motor_on_n ##1 host_i.motor_on_n |-> !mech_o.spindle)
    else $error("spindle on while motor-on high");

  head_load_a: assert property ( // see R19 see R20
    mech_o.head_load |-> sense_i.media_present && !st.ready_n && !host_i.head_load_n)
    else $error("head loaded without conditions");

  ready_idx_a: assert property ( // see R22
    rotating && index_fall ##1 rotating |-> !st.ready_n)
    else $error("ready not low after index");

  side_head_a: assert property ( // see R4
    mech_o.side1_head == !host_i.side_sel_n)
    else $error("wrong head side");

  // Stepping: ends saturate, phase order follows direction
  trk_top_a: assert property ( // see R7
    step_acc && !host_i.dir_n && st.track == FDIC_TRACK_MAX |=> st.track == FDIC_TRACK_MAX)
    else $error("inward step ran past the last track");

  trk_floor_a: assert property ( // see R8
    step_acc && host_i.dir_n && st.track == 8'h00 |=> st.track == 8'h00)
    else $error("outward step ran past track zero");

  phase_in_a: assert property ( // see R24
    step_acc && !host_i.dir_n
    |=> mech_o.phase == {$past(mech_o.phase[2:0]), $past(mech_o.phase[3])})
    else $error("inward phase order wrong");

  phase_out_a: assert property ( // see R24
    step_acc && host_i.dir_n
    |=> mech_o.phase == {$past(mech_o.phase[0]), $past(mech_o.phase[3:1])})
    else $error("outward phase order wrong");

  unsel_hold_a: assert property ( // see R1
    !selected && sense_i.track_zero_n |=> $stable(st.track) && $stable(st.phase_idx))
    else $error("head moved while not selected");

  strap_keep_a: assert property ( // see R2
    st.strap_done |=> $stable(st.drive_id))
    else $error("unit number changed after sampling");

  // Write path: every inhibit closes writing, toggling and erase start
  write_inhib_a: assert property ( // see R10 see R11
    !selected || sense_i.notch_covered || host_i.write_gate_n |-> !mech_o.write_enable)
    else $error("write enabled under an inhibit");

  wdata_gate_a: assert property ( // see R11
    !write_ok |=> $stable(mech_o.write_current))
    else $error("head current moved while writing inhibited");

  erase_quiet_a: assert property ( // see R14
    !mech_o.erase && !write_ok |=> !mech_o.erase)
    else $error("erase started without write gate");

  erase_keep_a: assert property ( // see R15
    mech_o.erase && write_ok |=> mech_o.erase)
    else $error("erase dropped while still writing");

  // Motor, ready, head load and output lines
  spin_on_a: assert property ( // see R17
    !host_i.motor_on_n ##1 !host_i.motor_on_n |-> mech_o.spindle)
    else $error("spindle off while motor-on low");

  ready_stop_a: assert property ( // see R22
    !rotating |=> st.ready_n)
    else $error("ready low without rotating media");

  ready_hold_a: assert property ( // see R22
    st.ready_n && !index_fall |=> st.ready_n)
    else $error("ready fell without an index");

  trk0_line_a: assert property ( // see R23
    selected |-> host_o.track0_n == sense_i.track_zero_n)
    else $error("track zero line wrong while selected");

  index_line_a: assert property ( // see R1
    selected |-> host_o.index_n == sense_i.index_n)
    else $error("index line wrong while selected");

  hload_sel_a: assert property ( // see R1
    mech_o.head_load |-> selected)
    else $error("head loaded while not selected");

  no_media_a: assert property ( // see R20
    !sense_i.media_present |-> !mech_o.head_load)
    else $error("head loaded with no media");

endmodule

/* fdic_erase_delay.sv */
// Purpose: Programmable turn-on and turn-off delay of the erase drive
// Assumes: Delay values are stable while a count is running
// Notes: A delay of zero behaves as one cycle
`timescale 1ns/1ps
module fdic_erase_delay
  import fdic_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic write_on_i,
  input wire logic [FDIC_DLY_W-1:0] on_dly_i,
  input wire logic [FDIC_DLY_W-1:0] off_dly_i,
  output logic erase_o
);

  typedef struct packed {
    logic erase;
    logic [FDIC_DLY_W-1:0] cnt;
  } fdic_erase_st_t;

  fdic_erase_st_t st;
  fdic_erase_st_t next_st;
  logic [FDIC_DLY_W-1:0] target;

  always_comb begin
    next_st = st;
    target = st.erase ? off_dly_i : on_dly_i;
    if (write_on_i != st.erase) begin
      // Count from the gate edge; a short gate pulse restarts the count
      if (st.cnt + 16'h0001 >= target) begin
        next_st.erase = write_on_i;
        next_st.cnt = '0;
      end else begin
        next_st.cnt = st.cnt + 16'h0001;
      end
    end else begin
      next_st.cnt = '0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign erase_o = st.erase;

endmodule

/* fdic_host_model.sv */
// Purpose: Host controller model driving the drive's host lines
// Assumes: Bench requests are levels or one-cycle pulses
// Notes: Write gate stays off until the settle wait has run out
`timescale 1ns/1ps
module fdic_host_model
  import fdic_pkg::*;
#(
  parameter int SETTLE = 8
)
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] unit_i,
  input wire logic sel_i,
  input wire logic dir_n_i,
  input wire logic side_n_i,
  input wire logic step_i,
  input wire logic gate_i,
  input wire logic wdat_i,
  input wire logic motor_i,
  input wire logic hload_i,
  input wire logic erase_i,
  output fdic_host_in_t host_o
);
  ////////////////////////////////////////
  logic [7:0] wait_cnt;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      host_o <= '1;
      wait_cnt <= 8'(SETTLE);
    end else begin
      host_o.drive_sel_n <= ~(4'(sel_i) << unit_i);
      host_o.dir_n <= dir_n_i;
      host_o.step_n <= ~step_i;
      host_o.write_data_n <= ~wdat_i;
      host_o.motor_on_n <= ~motor_i;
      host_o.head_load_n <= ~hload_i;
      // Tunnel erase trims the old side, so side waits for erase end
      if (host_o.write_gate_n && !erase_i) host_o.side_sel_n <= side_n_i;
      // One settle counter serves seek, side, spin-up and load waits
      if (step_i || side_n_i != host_o.side_sel_n || motor_i == host_o.motor_on_n ||
          hload_i == host_o.head_load_n) begin
        wait_cnt <= 8'(SETTLE);
      end else if (wait_cnt != 8'h00) begin
        wait_cnt <= wait_cnt - 8'h01;
      end
      host_o.write_gate_n <= ~gate_i | (host_o.write_gate_n & (wait_cnt != 8'h00));
    end
  end
endmodule

/* fdic_pkg.sv */
// Purpose: Shared constants and carriers for the drive interface control block
// Assumes: 200 MHz core clock, host lines already synchronous
// Notes: Register offsets are byte addresses on a 32-bit APB bus
package fdic_pkg;

  localparam int FDIC_CLK_PS = 5000;
  // Erase head delays, software may reprogram them
  localparam int FDIC_T1_NS = 1000;
  localparam int FDIC_T2_NS = 2000;
  localparam int FDIC_T1_CYC = (FDIC_T1_NS * 1000 + FDIC_CLK_PS - 1) / FDIC_CLK_PS;
  localparam int FDIC_T2_CYC = (FDIC_T2_NS * 1000 + FDIC_CLK_PS - 1) / FDIC_CLK_PS;

  localparam int FDIC_DLY_W = 16;
  localparam int FDIC_TRK_W = 8;
  localparam logic [FDIC_DLY_W-1:0] FDIC_ERASE_ON_RST = FDIC_T1_CYC[FDIC_DLY_W-1:0];
  localparam logic [FDIC_DLY_W-1:0] FDIC_ERASE_OFF_RST = FDIC_T2_CYC[FDIC_DLY_W-1:0];
  localparam logic [FDIC_TRK_W-1:0] FDIC_TRACK_MAX = 8'hFF;

  localparam logic [7:0] FDIC_ERASE_ON_OFS = 8'h00;
  localparam logic [7:0] FDIC_ERASE_OFF_OFS = 8'h04;
  localparam logic [7:0] FDIC_STATUS_OFS = 8'h08;
  localparam logic [7:0] FDIC_TRACK_OFS = 8'h0C;

  // Status and track register bit positions
  localparam int FDIC_ST_SEL = 0;
  localparam int FDIC_ST_SIDE1 = 1;
  localparam int FDIC_ST_WREN = 2;
  localparam int FDIC_ST_ERASE = 3;
  localparam int FDIC_ST_READY_N = 4;
  localparam int FDIC_ST_SPIN = 5;
  localparam int FDIC_ST_HLOAD = 6;
  localparam int FDIC_ST_TRK0_N = 7;
  localparam int FDIC_ST_ID = 8;
  localparam int FDIC_TRK_PHASE = 8;

  typedef enum logic [1:0] {
    FDIC_PH_A = 2'b00,
    FDIC_PH_B = 2'b01,
    FDIC_PH_C = 2'b10,
    FDIC_PH_D = 2'b11
  } fdic_phase_t;

  typedef struct packed {
    logic [3:0] drive_sel_n;
    logic side_sel_n;
    logic dir_n;
    logic step_n;
    logic write_gate_n;
    logic write_data_n;
    logic motor_on_n;
    logic head_load_n;
  } fdic_host_in_t;

  typedef struct packed {
    logic media_present;
    logic index_n;
    logic track_zero_n;
    logic notch_covered;
  } fdic_sense_t;

  typedef struct packed {
    logic ready_n;
    logic track0_n;
    logic write_protect_n;
    logic index_n;
  } fdic_host_out_t;

  typedef struct packed {
    logic [3:0] phase;
    logic side1_head;
    logic write_enable;
    logic write_current;
    logic erase;
    logic spindle;
    logic head_load;
    logic activity_led;
  } fdic_mech_out_t;

endpackage

/* floppy_drive_interface_control_tb.sv */
// Purpose: Self-checking bench for the drive interface control block
// Assumes: Host lines come from the host model, sense lines from here
// Notes: APB reads are checked through an expectation queue
`timescale 1ns/1ps
module floppy_drive_interface_control_tb;
  import fdic_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h3362;
  logic [1:0] unit = 2'h0, m_unit = 2'h0;
  logic sel = 1'b0, dir_n = 1'b0, side_n = 1'b1, step = 1'b0, gate = 1'b0;
  logic wdat = 1'b0, motor = 1'b0, hload = 1'b0;
  logic [15:0] on_d, off_d;
  fdic_sense_t sense = 4'hC;
  fdic_host_in_t host_in;
  fdic_host_out_t host_out;
  fdic_mech_out_t mech;
  logic [32:0] exp_q[$];
  int fails = 0, comparisons = 0, n;
  always #2.5 core_clk_i = ~core_clk_i;
  fdic_core i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .unit_jumper_i(unit),
    .host_i(host_in), .sense_i(sense), .host_o(host_out), .mech_o(mech));
  fdic_host_model i_host (.core_clk_i(core_clk_i), .rst_i(rst_i), .unit_i(m_unit),
    .sel_i(sel), .dir_n_i(dir_n), .side_n_i(side_n), .step_i(step), .gate_i(gate),
    .wdat_i(wdat), .motor_i(motor), .hload_i(hload), .erase_i(mech.erase),
    .host_o(host_in));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk_i);
  endtask
  // Read expectation carries the error flag in bit 32
  task automatic apb(input logic wr, input logic [7:0] a, input logic [32:0] d);
    int w;
    @(posedge core_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d[31:0];
    if (!wr) exp_q.push_back(d);
    @(posedge core_clk_i);
    penable <= 1'b1;
    w = 0;
    do begin
      @(posedge core_clk_i);
      w++;
    end while (pready !== 1'b1 && w < 50);
    if (w >= 50) begin
      fails++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Step or write data pulse, spaced by idle cycles
  task automatic pulse(input logic st, input logic d_n);
    dir_n <= d_n;
    step <= st;
    wdat <= !st;
    tick(1);
    step <= 1'b0;
    wdat <= 1'b0;
    tick(3);
  endtask
  // Cycles from write enable reaching v until erase follows
  task automatic erase_wait(input logic v);
    n = 0;
    while (mech.write_enable !== v && n < 1000) begin
      @(negedge core_clk_i);
      n++;
    end
    if (n >= 1000) begin
      fails++;
      test_done();
    end
    n = 0;
    while (mech.erase !== v && n < 1000) begin
      @(negedge core_clk_i);
      n++;
    end
    if (n >= 1000) begin
      fails++;
      test_done();
    end
    tick(1);
  endtask
  always @(posedge core_clk_i) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      chk({pslverr, prdata}, exp_q.pop_front());
    end
  end
  ////////////////////////////////////////
  initial begin
    seed = lfsr(seed);
    unit = seed[1:0];
    tick(4);
    rst_i <= 1'b0;
    tick(2);
    chk(mech.phase, 33'h1);
    chk(host_out, 33'hF);
    apb(1'b0, FDIC_ERASE_ON_OFS, {17'h0, FDIC_ERASE_ON_RST});
    apb(1'b0, FDIC_ERASE_OFF_OFS, {17'h0, FDIC_ERASE_OFF_RST});
    apb(1'b0, 8'h10, {1'b1, 32'h0});
    apb(1'b1, FDIC_TRACK_OFS, 33'h1FF);
    motor <= 1'b1;
    tick(3);
    chk(mech.spindle, 33'h1);
    for (int k = 0; k < 4; k++) begin
      m_unit <= 2'(k);
      sel <= 1'b1;
      tick(3);
      chk(mech.activity_led, 33'(unit == 2'(k)));
      chk(host_out.track0_n, 33'(unit != 2'(k)));
    end
    m_unit <= unit;
    for (int s = 0; s < 2; s++) begin
      side_n <= s[0];
      tick(3);
      chk(mech.side1_head, 33'(!s[0]));
    end
    sense.track_zero_n <= 1'b1;
    sel <= 1'b0;
    tick(2);
    pulse(1'b1, 1'b1);
    sel <= 1'b1;
    tick(2);
    repeat (3) pulse(1'b1, 1'b0);
    chk(mech.phase, 33'h8);
    pulse(1'b1, 1'b1);
    chk(mech.phase, 33'h4);
    apb(1'b0, FDIC_TRACK_OFS, 33'h202);
    pulse(1'b0, 1'b0);
    chk(mech.write_current, 33'h0);
    on_d = {12'h000, seed[3:0]} + 16'h0003;
    off_d = {12'h000, seed[7:4]} + 16'h0003;
    apb(1'b1, FDIC_ERASE_ON_OFS, {17'h0, on_d});
    apb(1'b1, FDIC_ERASE_OFF_OFS, {17'h0, off_d});
    apb(1'b0, FDIC_ERASE_OFF_OFS, {17'h0, off_d});
    gate <= 1'b1;
    erase_wait(1'b1);
    chk(n, on_d);
    for (int i = 0; i <= seed[9:8]; i++) begin
      pulse(1'b0, 1'b0);
      chk(mech.write_current, 33'(i[0] == 1'b0));
    end
    chk(mech.write_enable, 33'h1);
    gate <= 1'b0;
    erase_wait(1'b0);
    chk(n, off_d);
    sense.notch_covered <= 1'b1;
    gate <= 1'b1;
    tick(12);
    chk(mech.write_enable, 33'h0);
    chk(host_out.write_protect_n, 33'h0);
    gate <= 1'b0;
    chk(host_out.ready_n, 33'h1);
    apb(1'b0, FDIC_STATUS_OFS, {23'h0, unit, 8'hB1});
    hload <= 1'b1;
    tick(3);
    chk(mech.head_load, 33'h0);
    sense.index_n <= 1'b0;
    tick(1);
    chk(host_out.index_n, 33'h0);
    sense.index_n <= 1'b1;
    tick(3);
    chk(host_out.ready_n, 33'h0);
    chk(mech.head_load, 33'h1);
    sel <= 1'b0;
    tick(2);
    chk(mech.head_load, 33'h0);
    sel <= 1'b1;
    sense.media_present <= 1'b0;
    tick(3);
    chk(mech.head_load, 33'h0);
    chk(host_out.ready_n, 33'h1);
    motor <= 1'b0;
    tick(3);
    chk(mech.spindle, 33'h0);
    tick(2);
    chk(exp_q.size(), 33'h0);
    test_done();
  end
endmodule
